// [hcs_pkg.sv]
// constants, types and register map of the configuration source selector
package hcs_pkg;

  // register byte offsets
  localparam logic [11:0] HCS_OFS_CTRL   = 12'h000;
  localparam logic [11:0] HCS_OFS_STATUS = 12'h004;

  // control register fields and reset value
  localparam int          HCS_CTRL_AMP_PD  = 0;
  localparam int          HCS_CTRL_DL_HOLD = 1;
  localparam logic [1:0]  HCS_CTRL_RST     = 2'h0;

  // status register fields
  localparam int          HCS_ST_VALID    = 0;
  localparam int          HCS_ST_MODE_LO  = 1;
  localparam int          HCS_ST_STRAP_LO = 6;
  localparam int          HCS_ST_LPWR     = 9;
  localparam int          HCS_ST_EXTCLK   = 10;
  localparam int          HCS_ST_ADDR_LO  = 11;
  localparam int          HCS_ST_MOVED    = 18;

  // slave addresses answered in the two bus-slave modes
  localparam logic [6:0]  HCS_SMB_ADDR_A  = 7'h2C;
  localparam logic [6:0]  HCS_SMB_ADDR_B  = 7'h2D;
  localparam logic [6:0]  HCS_SMB_ADDR_RST = 7'h00;

  // timing
  localparam int          HCS_CLK_HZ       = 40_000_000;
  localparam int          HCS_CLK_PERIOD_NS = 25;
  localparam int          HCS_REF_CLK_HZ   = 24_000_000;
  localparam int          HCS_RST_MIN_NS   = 1000;
  localparam int          HCS_RST_MIN_CYC  =
    (HCS_RST_MIN_NS + HCS_CLK_PERIOD_NS - 1) / HCS_CLK_PERIOD_NS;
  // edges after release before the filtered straps are trusted
  localparam logic [2:0]  HCS_CAPTURE_CYC  = 3'h4;
  localparam logic [2:0]  HCS_CNT_RST      = 3'h0;

  // synchroniser lanes
  localparam int          HCS_NUM_PINS = 5;
  localparam int          HCS_PIN_LO   = 0;
  localparam int          HCS_PIN_MID  = 1;
  localparam int          HCS_PIN_HI   = 2;
  localparam int          HCS_PIN_EXT  = 3;
  localparam int          HCS_PIN_LPWR = 4;

  typedef enum logic [4:0] {
    HCS_SMB_A     = 5'h01,
    HCS_SMB_B     = 5'h02,
    HCS_DEF       = 5'h04,
    HCS_DEF_STRAP = 5'h08,
    HCS_EEPROM    = 5'h10
  } hcs_mode_t;

  typedef struct packed {
    hcs_mode_t  mode;
    logic [6:0] smb_addr;
    logic       smb_en;
    logic       eeprom_en;
    logic       strap_ovr;
    logic       valid;
  } hcs_cfg_t;

  typedef struct packed {
    logic hi;
    logic mid;
    logic lo;
  } hcs_strap_t;

endpackage : hcs_pkg

// [hcs_top.sv]
// configuration source selector: strap decode at reset release, clock and power select
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps

module hcs_top (
  // clock and reset
  input  wire  logic                CLK,
  input  wire  logic                RESET_N,
  // board pins
  input  wire  logic                CFG_SOURCE_STRAP_HI,
  input  wire  logic                CFG_SOURCE_STRAP_MID,
  input  wire  logic                CFG_SOURCE_STRAP_LO,
  input  wire  logic                EXT_CLOCK_SELECT,
  input  wire  logic                LOCAL_POWER_DETECT,
  // oscillator control
  output logic                      XTAL_AMP_EN,
  output logic                      EXT_CLK_SEL,
  // decoded configuration
  output hcs_pkg::hcs_cfg_t         CFG,
  output logic                      SELF_POWERED,
  // apb slave
  input  wire  logic                PSEL,
  input  wire  logic                PENABLE,
  input  wire  logic                PWRITE,
  input  wire  logic [11:0]         PADDR,
  input  wire  logic [31:0]         PWDATA,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR
);

  logic [hcs_pkg::HCS_NUM_PINS-1:0] pin_raw;
  logic [hcs_pkg::HCS_NUM_PINS-1:0] pin_s1_reg;
  logic [hcs_pkg::HCS_NUM_PINS-1:0] pin_s2_reg;
  logic [hcs_pkg::HCS_NUM_PINS-1:0] pin_s3_reg;
  logic [hcs_pkg::HCS_NUM_PINS-1:0] pin_flt_reg;
  logic [2:0]                       cap_cnt_reg;
  logic                             locked_reg;
  hcs_pkg::hcs_strap_t              strap_now;
  hcs_pkg::hcs_strap_t              strap_reg;
  hcs_pkg::hcs_mode_t               mode_reg;
  logic                             ext_clk_reg;
  logic                             lpwr_reg;
  logic [1:0]                       ctrl_reg;
  logic                             moved_reg;
  logic                             moved_set;
  logic                             moved_clr;
  logic                             acc;
  logic                             wr;
  logic                             hit_ctrl;
  logic                             hit_status;
  logic [31:0]                      status_word;
  logic [31:0]                      rdata;

  // select-strap decode: strap hi only matters when mid,lo read 1,0
  function automatic hcs_pkg::hcs_mode_t decode_src(input hcs_pkg::hcs_strap_t s);
    hcs_pkg::hcs_mode_t m;
    m = hcs_pkg::HCS_DEF;
    unique case ({s.mid, s.lo})
      2'h0: m = hcs_pkg::HCS_SMB_A;
      2'h1: m = hcs_pkg::HCS_SMB_B;
      2'h2: m = s.hi ? hcs_pkg::HCS_DEF_STRAP : hcs_pkg::HCS_DEF;
      2'h3: m = hcs_pkg::HCS_EEPROM;
    endcase
    return m;
  endfunction : decode_src

  function automatic logic [6:0] slave_addr(input hcs_pkg::hcs_mode_t m);
    logic [6:0] a;
    a = hcs_pkg::HCS_SMB_ADDR_RST;
    if (m == hcs_pkg::HCS_SMB_A) begin
      a = hcs_pkg::HCS_SMB_ADDR_A;
    end else if (m == hcs_pkg::HCS_SMB_B) begin
      a = hcs_pkg::HCS_SMB_ADDR_B;
    end
    return a;
  endfunction : slave_addr

  assign pin_raw[hcs_pkg::HCS_PIN_LO]   = CFG_SOURCE_STRAP_LO;
  assign pin_raw[hcs_pkg::HCS_PIN_MID]  = CFG_SOURCE_STRAP_MID;
  assign pin_raw[hcs_pkg::HCS_PIN_HI]   = CFG_SOURCE_STRAP_HI;
  assign pin_raw[hcs_pkg::HCS_PIN_EXT]  = EXT_CLOCK_SELECT;
  assign pin_raw[hcs_pkg::HCS_PIN_LPWR] = LOCAL_POWER_DETECT;

  // three-stage synchroniser per pin; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < hcs_pkg::HCS_NUM_PINS; gi = gi + 1) begin : g_sync
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          pin_s1_reg[gi]  <= 1'b0;
          pin_s2_reg[gi]  <= 1'b0;
          pin_s3_reg[gi]  <= 1'b0;
          pin_flt_reg[gi] <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
            pin_flt_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  assign strap_now.hi  = pin_flt_reg[hcs_pkg::HCS_PIN_HI];
  assign strap_now.mid = pin_flt_reg[hcs_pkg::HCS_PIN_MID];
  assign strap_now.lo  = pin_flt_reg[hcs_pkg::HCS_PIN_LO];

  // straps are static around release, so the level seen once the
  // synchroniser has filled is the level at the rising reset edge
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cap_cnt_reg <= hcs_pkg::HCS_CNT_RST;
      locked_reg  <= 1'b0;
    end else if (!locked_reg) begin
      if (cap_cnt_reg == hcs_pkg::HCS_CAPTURE_CYC) begin
        locked_reg <= 1'b1;
      end else begin
        cap_cnt_reg <= cap_cnt_reg + 3'h1;
      end
    end
  end

  // capture once; nothing but the next reset reopens it
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_reg   <= '0;
      mode_reg    <= hcs_pkg::HCS_DEF;
      ext_clk_reg <= 1'b0;
    end else if (!locked_reg && cap_cnt_reg == hcs_pkg::HCS_CAPTURE_CYC) begin
      strap_reg   <= strap_now;
      mode_reg    <= decode_src(strap_now);
      // clock source latched too: switching it live would glitch the core clock
      ext_clk_reg <= pin_flt_reg[hcs_pkg::HCS_PIN_EXT];
    end
  end

  // power source may change at any time (dynamic power)
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lpwr_reg <= 1'b0;
    end else begin
      lpwr_reg <= pin_flt_reg[hcs_pkg::HCS_PIN_LPWR];
    end
  end

  // later strap movement is ignored but reported
  assign moved_set = locked_reg && (strap_now != strap_reg);
  assign moved_clr = wr && hit_status && PWDATA[hcs_pkg::HCS_ST_MOVED];

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      moved_reg <= 1'b0;
    end else if (moved_set) begin
      moved_reg <= 1'b1;
    end else if (moved_clr) begin
      moved_reg <= 1'b0;
    end
  end

  // decoded configuration towards the loaders
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CFG <= '{mode: hcs_pkg::HCS_DEF, smb_addr: hcs_pkg::HCS_SMB_ADDR_RST,
               smb_en: 1'b0, eeprom_en: 1'b0, strap_ovr: 1'b0, valid: 1'b0};
    end else begin
      CFG.mode      <= mode_reg;
      CFG.smb_addr  <= slave_addr(mode_reg);
      CFG.smb_en    <= locked_reg && !ctrl_reg[hcs_pkg::HCS_CTRL_DL_HOLD] &&
                       (mode_reg == hcs_pkg::HCS_SMB_A ||
                        mode_reg == hcs_pkg::HCS_SMB_B);
      CFG.eeprom_en <= locked_reg && !ctrl_reg[hcs_pkg::HCS_CTRL_DL_HOLD] &&
                       (mode_reg == hcs_pkg::HCS_EEPROM);
      CFG.strap_ovr <= locked_reg && (mode_reg == hcs_pkg::HCS_DEF_STRAP);
      CFG.valid     <= locked_reg;
    end
  end

  // oscillator: amplifier only runs in crystal mode, software may power it down
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      XTAL_AMP_EN  <= 1'b1;
      EXT_CLK_SEL  <= 1'b0;
      SELF_POWERED <= 1'b0;
    end else begin
      XTAL_AMP_EN  <= !ext_clk_reg && !ctrl_reg[hcs_pkg::HCS_CTRL_AMP_PD];
      EXT_CLK_SEL  <= ext_clk_reg;
      SELF_POWERED <= lpwr_reg;
    end
  end

  // apb slave, zero wait states
  assign acc        = PSEL && PENABLE;
  assign wr         = acc && PWRITE;
  assign hit_ctrl   = (PADDR == hcs_pkg::HCS_OFS_CTRL);
  assign hit_status = (PADDR == hcs_pkg::HCS_OFS_STATUS);
  assign PREADY     = 1'b1;
  assign PSLVERR    = acc && !hit_ctrl && !hit_status;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= hcs_pkg::HCS_CTRL_RST;
    end else if (wr && hit_ctrl) begin
      ctrl_reg <= PWDATA[1:0];
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[hcs_pkg::HCS_ST_VALID] = locked_reg;
    status_word[hcs_pkg::HCS_ST_MODE_LO +: 5] = mode_reg;
    status_word[hcs_pkg::HCS_ST_STRAP_LO +: 3] = strap_reg;
    status_word[hcs_pkg::HCS_ST_LPWR] = lpwr_reg;
    status_word[hcs_pkg::HCS_ST_EXTCLK] = ext_clk_reg;
    status_word[hcs_pkg::HCS_ST_ADDR_LO +: 7] = slave_addr(mode_reg);
    status_word[hcs_pkg::HCS_ST_MOVED] = moved_reg;
  end

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata = {30'h0000_0000, ctrl_reg};
    end else if (hit_status) begin
      rdata = status_word;
    end
  end

  // read data registered at the setup cycle so it is stable in the access phase
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata;
    end
  end

endmodule : hcs_top

// [hcs_brd.sv]
// board straps and system reset model
`timescale 1ns/10ps
module hcs_brd (
  // bench control
  input  wire logic       clk,
  input  wire logic       pulse,
  input  wire logic [4:0] pins_in,
  // board side
  output logic            rst_n,
  output logic [4:0]      pins
);
  int cnt = 16;
  assign rst_n = (cnt == 0);
  // strap resistors always drive a level
  assign pins = pins_in;
  always @(posedge clk) begin
    if (pulse) cnt <= 40;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule : hcs_brd

// [hcs_props.sv]
// assertions on the configuration source selector ports
`timescale 1ns/10ps
module hcs_props (
  // clock and reset
  input wire logic              CLK,
  input wire logic              RESET_N,
  // board pins
  input wire logic              CFG_SOURCE_STRAP_HI,
  input wire logic              CFG_SOURCE_STRAP_MID,
  input wire logic              CFG_SOURCE_STRAP_LO,
  input wire logic              EXT_CLOCK_SELECT,
  input wire logic              LOCAL_POWER_DETECT,
  // outputs
  input wire logic              XTAL_AMP_EN,
  input wire logic              EXT_CLK_SEL,
  input wire hcs_pkg::hcs_cfg_t CFG,
  input wire logic              SELF_POWERED,
  // apb
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [11:0]       PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic [1:0] sel;
  assign sel = {CFG_SOURCE_STRAP_MID, CFG_SOURCE_STRAP_LO};
  slave_a_a: assert property ($rose(CFG.valid) && sel == 2'h0 |->
    CFG.mode == hcs_pkg::HCS_SMB_A && CFG.smb_addr == 7'h2C) else $error("slave A decode");
  slave_b_a: assert property ($rose(CFG.valid) && sel == 2'h1 |->
    CFG.mode == hcs_pkg::HCS_SMB_B && CFG.smb_addr == 7'h2D) else $error("slave B decode");
  defaults_a: assert property ($rose(CFG.valid) && sel == 2'h2 |->
    CFG.mode == (CFG_SOURCE_STRAP_HI ? hcs_pkg::HCS_DEF_STRAP : hcs_pkg::HCS_DEF))
    else $error("default decode");
  eeprom_a: assert property ($rose(CFG.valid) && sel == 2'h3 |->
    CFG.mode == hcs_pkg::HCS_EEPROM) else $error("eeprom decode");
  sample_time_a: assert property ($rose(RESET_N) |->
    !CFG.valid [*5] ##[1:2] CFG.valid) else $error("capture timing");
  lock_hold_a: assert property (CFG.valid |=>
    CFG.valid && $stable(CFG.mode) && $stable(EXT_CLK_SEL)) else $error("source moved");
  clk_sel_a: assert property ($rose(CFG.valid) |->
    EXT_CLK_SEL == EXT_CLOCK_SELECT) else $error("clock select");
  amp_off_a: assert property (EXT_CLK_SEL ##1 EXT_CLK_SEL |-> !XTAL_AMP_EN)
    else $error("amplifier on with external clock");
  power_a: assert property ($changed(LOCAL_POWER_DETECT) ##1
    $stable(LOCAL_POWER_DETECT) [*6] |-> SELF_POWERED == LOCAL_POWER_DETECT)
    else $error("power detect");
  apb_resp_a: assert property (PSEL && PENABLE |->
    PREADY && PSLVERR == (PADDR[11:3] != 9'h0 || PADDR[1:0] != 2'h0)) else $error("apb response");
  cover property ($rose(CFG.valid) && sel == 2'h0);
  cover property ($rose(CFG.valid) && sel == 2'h3);
  cover property (PSEL && PENABLE && PSLVERR);
endmodule : hcs_props
bind hcs_top hcs_props chk (.CLK, .RESET_N, .CFG_SOURCE_STRAP_HI, .CFG_SOURCE_STRAP_MID,
  .CFG_SOURCE_STRAP_LO, .EXT_CLOCK_SELECT, .LOCAL_POWER_DETECT, .XTAL_AMP_EN, .EXT_CLK_SEL,
  .CFG, .SELF_POWERED, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);

// [tb.sv]
// self-checking bench for the configuration source selector
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0, pulse = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [4:0] pins_in = 5'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic rst_n, pready, pslverr, amp_en, ext_sel, local_power_detect, err;
  logic [4:0] pins;
  hcs_pkg::hcs_cfg_t cfg;
  int fails = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  hcs_brd brd (.clk(clk), .pulse(pulse), .pins_in(pins_in), .rst_n(rst_n), .pins(pins));
  hcs_top dut (.CLK(clk), .RESET_N(rst_n), .CFG_SOURCE_STRAP_HI(pins[2]),
    .CFG_SOURCE_STRAP_MID(pins[1]), .CFG_SOURCE_STRAP_LO(pins[0]), .EXT_CLOCK_SELECT(pins[3]),
    .LOCAL_POWER_DETECT(pins[4]), .XTAL_AMP_EN(amp_en), .EXT_CLK_SEL(ext_sel), .CFG(cfg),
    .SELF_POWERED(local_power_detect), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check(32'h0, 32'h1);
    if (n >= 20) summarize();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // straps change only while reset is held, so they are steady at release
  task automatic do_reset(input logic [4:0] p);
    int n;
    n = 0;
    @(posedge clk);
    pulse   <= 1'b1;
    @(posedge clk);
    pins_in <= p;
    pulse   <= 1'b0;
    // let reset reach the block before looking for the next lock
    @(posedge clk);
    while (!(rst_n === 1'b1 && cfg.valid === 1'b1) && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) check(32'h0, 32'h1);
    if (n >= 100) summarize();
    repeat (8) @(posedge clk);
  endtask : do_reset
  task automatic t_decode;
    hcs_pkg::hcs_mode_t m;
    logic [6:0] a;
    for (int i = 0; i < 32; i++) begin
      do_reset(5'(i));
      a = 7'h00;
      case (i[1:0])
        2'h0: begin m = hcs_pkg::HCS_SMB_A; a = 7'h2C; end
        2'h1: begin m = hcs_pkg::HCS_SMB_B; a = 7'h2D; end
        2'h2: m = i[2] ? hcs_pkg::HCS_DEF_STRAP : hcs_pkg::HCS_DEF;
        default: m = hcs_pkg::HCS_EEPROM;
      endcase
      check(32'(cfg.mode), 32'(m));
      check(32'(cfg.smb_addr), 32'(a));
      check(32'(ext_sel), 32'(i[3]));
      check(32'(amp_en), 32'(!i[3]));
      check(32'(local_power_detect), 32'(i[4]));
      check(32'(cfg.valid), 32'h1);
      check(32'(cfg.smb_en), 32'(!i[1]));
      check(32'(cfg.eeprom_en), 32'(i[1:0] == 2'h3));
      check(32'(cfg.strap_ovr), 32'(i[2:0] == 3'h6));
    end
  endtask : t_decode
  task automatic t_lock;
    do_reset(5'h00);
    @(posedge clk);
    pins_in <= 5'h1B;
    repeat (10) @(posedge clk);
    check(32'(cfg.mode), 32'(hcs_pkg::HCS_SMB_A));
    check(32'(ext_sel), 32'h0);
    check(32'(local_power_detect), 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check(32'(rd[18]), 32'h1);
    check(32'(rd[5:0]), 32'h03);
  endtask : t_lock
  task automatic t_apb;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    check(32'(cfg.smb_en), 32'h1);
    apb(1'b1, 12'h000, 32'h3);
    repeat (2) @(posedge clk);
    check(32'(amp_en), 32'h0);
    check(32'(cfg.smb_en), 32'h0);
    // straps still differ from the latched set, so a clear loses to the set
    apb(1'b1, 12'h004, 32'h0004_0000);
    apb(1'b0, 12'h004, 32'h0);
    check(32'(rd[18]), 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h3);
  endtask : t_apb
  initial begin
    t_decode();
    t_lock();
    t_apb();
    summarize();
  end
endmodule : tb
